// File: dv/pcpa_pad_model.sv
// Pad model: the far end of every port pin.
// Assumes pad_out and pad_oe come straight from the crossbar top.
`timescale 1ns/1ps
module pcpa_pad_model (
	input wire logic [15:0] pad_out,
	input wire logic [15:0] pad_oe,
	input wire logic [15:0] ext_level,
	output logic [15:0] pad_in
);
	// Driven pads show the crossbar value, released pads the far end
	assign pad_in = (pad_oe & pad_out) | (~pad_oe & ext_level);
endmodule

// File: dv/pcpa_xbar_bench.sv
// Self-checking bench for the crossbar pin assigner.
// Assumes pcpa_xbar and the pad model; seeded random configs.
`timescale 1ns/1ps
module pcpa_xbar_bench;
	logic core_clk, rst, gen;
	logic [7:0] ra, rb, rc, sa, sb, eic, ama, amv, bma, bmv;
	logic [1:0] ssm;
	logic [15:0] oms, die, lat, ext, pad_out, pad_oe, pad_in;
	logic [15:0] e_oe, e_out, e_lv;
	logic [25:0] fout, fdrv, fn_in, e_fin;
	logic i0l, i1l, i0e, i1e, pm, e_i0, e_i1, e_pm;
	logic [4:0] fac, e_fac;
	int mismatches = 0;
	int samples_checked = 0;
	int cycles = 0;

	pcpa_xbar i_dut (.core_clk(core_clk), .rst(rst),
		.crossbar_global_enable(gen), .crossbar_enable_reg_a(ra),
		.crossbar_enable_reg_b(rb), .crossbar_enable_reg_c(rc),
		.port_a_skip_mask(sa), .port_b_skip_mask(sb),
		.slave_select_mode_field(ssm), .output_mode_select(oms),
		.digital_input_enable(die), .port_latch(lat), .pad_in(pad_in),
		.pad_out(pad_out), .pad_oe(pad_oe), .fn_out(fout),
		.fn_drive(fdrv), .fn_in(fn_in), .ext_int_pin_config(eic),
		.port_a_match_mask(ama), .port_a_match_value(amv),
		.port_b_match_mask(bma), .port_b_match_value(bmv),
		.int0_level(i0l), .int1_level(i1l), .int0_edge(i0e),
		.int1_edge(i1e), .port_match(pm), .fixed_analog_connect(fac));
	pcpa_pad_model i_pads (.pad_out(pad_out), .pad_oe(pad_oe),
		.ext_level(ext), .pad_in(pad_in));

	// ----------------------------------------
	// Reference model
	// ----------------------------------------
	function automatic bit want(int s);
		case (s)
			6, 7, 8: return ra[1];
			9: return ra[1] & ssm[1];
			10, 11: return ra[2];
			12: return ra[4];
			13: return ra[5];
			14: return ra[6];
			15: return ra[7];
			16: return ra[3];
			23: return rb[3];
			24: return rb[4];
			25: return rb[5];
			default: return s >= 17 && s < 23 && (s - 17) < rb[2:0];
		endcase
	endfunction

	task automatic calc();
		logic [14:0] fr;
		int own [16];
		int s, p;
		logic v, d, pp;
		logic [15:0] lv;
		for (p = 0; p < 16; p++) own[p] = -1;
		fr = ~{sb[6:0], sa};
		if (ra[0]) begin
			own[4] = 0;
			own[5] = 1;
			fr[5:4] = 2'h0;
		end
		if (rc[0]) begin
			for (p = 0; p < 4; p++) own[8 + p] = 2 + p;
			fr[11:8] = 4'h0;
		end
		for (s = 6; s < 26; s++) begin
			if (want(s)) begin
				for (p = 0; p < 15; p++) begin
					if (fr[p]) begin
						own[p] = s;
						fr[p] = 1'b0;
						break;
					end
				end
			end
		end
		e_fin = '1;
		for (p = 0; p < 16; p++) begin
			s = own[p];
			v = (s < 0) ? lat[p] : fout[s];
			d = (s < 0) ? 1'b1 : fdrv[s];
			pp = oms[p] & !(s == 10 || s == 11);
			e_oe[p] = gen & d & (pp | ~v);
			e_out[p] = v;
			e_lv[p] = e_oe[p] ? v : ext[p];
			if (s >= 0) e_fin[s] = e_lv[p] & die[p];
		end
		lv = e_lv & die;
		e_i0 = lv[eic[2:0]] == eic[3];
		e_i1 = lv[eic[6:4]] == eic[7];
		e_pm = |((lv[14:0] ^ {bmv[6:0], amv}) & {bma[6:0], ama});
		e_fac = ~{die[7], die[3:0]};
	endtask

	// ----------------------------------------
	// Checks and stimulus
	// ----------------------------------------
	task automatic cmp_vec(input logic [25:0] got, input logic [25:0] exp,
			input string what);
		samples_checked++;
		if (got !== exp) begin
			mismatches++;
			$display("ERROR %0t %s got %h exp %h", $time, what, got, exp);
		end
	endtask

	task automatic check_pins();
		calc();
		cmp_vec(26'(pad_oe), 26'(e_oe), "oe");
		cmp_vec(26'(pad_out), 26'(e_out), "out");
		cmp_vec(fn_in, e_fin, "fn_in");
		cmp_vec(26'(fac), 26'(e_fac), "analog");
		cmp_vec(26'({i0l, i1l, pm}), 26'({e_i0, e_i1, e_pm}), "evt");
		cmp_vec(26'({i0e, i1e}), 26'h0, "edge");
	endtask

	task automatic set(input logic g, input logic [7:0] a, b, c, s0, s1,
			input logic [1:0] m);
		@(posedge core_clk);
		gen <= g;
		ra <= a;
		rb <= b;
		rc <= c;
		sa <= s0;
		sb <= s1;
		ssm <= m;
		oms <= 16'($urandom);
		die <= 16'($urandom | $urandom);
		lat <= 16'($urandom);
		ext <= 16'($urandom);
		fout <= 26'($urandom);
		fdrv <= 26'($urandom | $urandom);
		eic <= 8'($urandom);
		{ama, amv, bma, bmv} <= $urandom;
		@(posedge core_clk);
		@(negedge core_clk);
		calc();
		cmp_vec(26'({pad_oe, fac}), 26'({e_oe, e_fac}), "lat1");
		cmp_vec(26'(pad_out), 26'(e_out), "lat1");
		repeat (2) @(posedge core_clk);
		@(negedge core_clk);
		check_pins();
	endtask

	task automatic edge_test(input bit w, input logic [2:0] p,
			input bit pol, input bit ana);
		@(posedge core_clk);
		gen <= 1'b0;
		eic <= w ? {pol, p, 4'h0} : {4'h0, pol, p};
		die <= ana ? ~(16'h1 << p) : 16'hFFFF;
		ext <= pol ? 16'h0000 : 16'hFFFF;
		repeat (3) @(posedge core_clk);
		ext[p] <= pol;
		@(posedge core_clk);
		@(negedge core_clk);
		cmp_vec(26'(w ? {i1e, i1l} : {i0e, i0l}), 26'({2{~ana}}), "ev");
		@(negedge core_clk);
		cmp_vec(26'(w ? {i1e, i1l} : {i0e, i0l}), 26'({1'b0, ~ana}), "ev");
	endtask

	task automatic print_verdict();
		$display("checked %0d mismatches %0d", samples_checked, mismatches);
		if (mismatches == 0 && samples_checked > 0) begin
			$display("Result: passed");
		end else begin
			$display("Result: failed");
		end
		$finish;
	endtask

	initial begin
		core_clk = 1'b0;
		forever #12.5 core_clk = ~core_clk;
	end

	always @(posedge core_clk) begin
		cycles++;
		if (cycles == 5000) begin
			mismatches++;
			print_verdict();
		end
	end

	initial begin
		int i;
		rst = 1'b1;
		{gen, ra, rb, rc, sa, sb, ssm, eic, ama, amv, bma, bmv} = '0;
		{oms, die, lat, ext, fout, fdrv} = '0;
		void'($urandom(32'hd9ead7ab));
		@(negedge core_clk);
		cmp_vec(26'({pad_oe, fac}), 26'h0, "reset");
		cmp_vec(26'({pad_out, i0l, i1l, i0e, i1e, pm}), 26'h0, "reset");
		cmp_vec(fn_in, '1, "reset");
		@(posedge core_clk);
		rst <= 1'b0;
		set(1, 8'hFF, 8'h3E, 8'h01, 8'h00, 8'h00, 2'b10);
		set(1, 8'hFF, 8'h3E, 8'h01, 8'h0C, 8'h00, 2'b10);
		set(1, 8'hFF, 8'h3E, 8'h01, 8'h0C, 8'h00, 2'b00);
		set(1, 8'hFF, 8'h3F, 8'h01, 8'hFF, 8'h7F, 2'b10);
		set(1, 8'hFE, 8'h3E, 8'h00, 8'h00, 8'h00, 2'b10);
		set(0, 8'hFF, 8'h3E, 8'h01, 8'h00, 8'h00, 2'b10);
		for (i = 0; i < 16; i++) edge_test(i[1] ^ i[2], i[3:1], i[0],
			i[0] & i[1]);
		for (i = 0; i < 150; i++) begin
			set(($urandom % 8) != 0, 8'($urandom),
				{2'h0, 3'($urandom), 3'($urandom_range(0, 6))},
				8'($urandom), 8'($urandom), 8'($urandom),
				2'($urandom));
		end
		print_verdict();
	end
endmodule

// File: verilog/pcpa_evt.sv
// External interrupt and port match capture on digital pins.
// Assumes pin inputs already gated to zero on analog pins.
`timescale 1ns/1ps
module pcpa_evt #(
	parameter int W = 15
) (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic [W-1:0] pin_in,
	input wire logic [7:0] ext_int_pin_config,
	input wire logic [W-1:0] match_mask,
	input wire logic [W-1:0] match_value,
	output logic int0_level,
	output logic int1_level,
	output logic int0_edge,
	output logic int1_edge,
	output logic port_match
);
	wire [7:0] p0;
	wire lvl0;
	wire lvl1;
	wire match_nxt;
	logic lvl0_r;
	logic lvl1_r;

	assign p0 = pin_in[7:0];
	// Low three bits pick the pin, top bit is active-high select
	assign lvl0 = p0[ext_int_pin_config[2:0]] ^
		~ext_int_pin_config[3];
	assign lvl1 = p0[ext_int_pin_config[6:4]] ^
		~ext_int_pin_config[7];
	assign match_nxt = |((pin_in ^ match_value) & match_mask);

	always_ff @(posedge core_clk) begin
		if (rst) begin
			lvl0_r <= 1'b0;
			lvl1_r <= 1'b0;
			int0_edge <= 1'b0;
			int1_edge <= 1'b0;
			port_match <= 1'b0;
		end else begin
			lvl0_r <= lvl0;
			lvl1_r <= lvl1;
			int0_edge <= lvl0 & ~lvl0_r;
			int1_edge <= lvl1 & ~lvl1_r;
			port_match <= match_nxt;
		end
	end

	assign int0_level = lvl0_r;
	assign int1_level = lvl1_r;
endmodule

// File: verilog/pcpa_pkg.sv
// Constants for the priority crossbar pin assigner.
// Assumes one system clock and plain configuration ports.
package pcpa_pkg;
	localparam int NPIN = 15;
	localparam int NPAD = 16;
	localparam int NFUNC = 26;
	localparam int NFIX = 6;
	localparam int NCEX = 6;
	// Pad indices
	localparam int PIN_VREF = 0;
	localparam int PIN_ANALOG_GROUND_PIN = 1;
	localparam int PIN_XIN = 2;
	localparam int PIN_XOUT = 3;
	localparam int PIN_TX = 4;
	localparam int PIN_RX = 5;
	localparam int PIN_IREF = 7;
	localparam int PIN_SPIB = 8;
	localparam int PAD_GPIO2 = 15;
	// Function slots, in priority order
	localparam int F_TX = 0;
	localparam int F_RX = 1;
	localparam int F_SPIB = 2;
	localparam int F_SCKA = 6;
	localparam int F_MISOA = 7;
	localparam int F_MOSIA = 8;
	localparam int F_NSSA = 9;
	localparam int F_SDA = 10;
	localparam int F_SCL = 11;
	localparam int F_CMPA = 12;
	localparam int F_CMPAA = 13;
	localparam int F_CMPB = 14;
	localparam int F_CMPBA = 15;
	localparam int F_SYSCK = 16;
	localparam int F_CEX = 17;
	localparam int F_ECI = 23;
	localparam int F_T0 = 24;
	localparam int F_T1 = 25;
	// Enable register A bits
	localparam int RA_URT = 0;
	localparam int RA_SPIA = 1;
	localparam int RA_SMB = 2;
	localparam int RA_SYSCK = 3;
	localparam int RA_CMPA = 4;
	localparam int RA_CMPAA = 5;
	localparam int RA_CMPB = 6;
	localparam int RA_CMPBA = 7;
	// Enable register B and C bits, slave select mode field bit
	localparam int RB_CEX_LO = 0;
	localparam int RB_CEX_HI = 2;
	localparam int RB_ECI = 3;
	localparam int RB_T0 = 4;
	localparam int RB_T1 = 5;
	localparam int RC_SPIB = 0;
	localparam int SSM_4WIRE = 1;
endpackage

// File: verilog/pcpa_slot.sv
// One crossbar search step: a requesting function takes the
// lowest free pin. Purely combinational; chained by the caller.
`timescale 1ns/1ps
module pcpa_slot #(
	parameter int W = 15
) (
	input wire logic req,
	input wire logic [W-1:0] free_in,
	output logic [W-1:0] grant,
	output logic [W-1:0] free_out
);
	wire [W-1:0] lowest;

	// Lowest set bit of the free mask
	assign lowest = free_in & (~free_in + {{(W-1){1'b0}}, 1'b1});
	assign grant = req ? lowest : {W{1'b0}};
	assign free_out = free_in & ~grant;
endmodule

// File: verilog/pcpa_xbar.sv
// Top of the priority crossbar pin assigner.
// Assumes peripherals and pads are synchronous to core_clk.
`timescale 1ns/1ps
module pcpa_xbar (
	input wire logic core_clk,
	input wire logic rst,
	input wire logic crossbar_global_enable,
	input wire logic [7:0] crossbar_enable_reg_a,
	input wire logic [7:0] crossbar_enable_reg_b,
	input wire logic [7:0] crossbar_enable_reg_c,
	input wire logic [7:0] port_a_skip_mask,
	input wire logic [7:0] port_b_skip_mask,
	input wire logic [1:0] slave_select_mode_field,
	input wire logic [15:0] output_mode_select,
	input wire logic [15:0] digital_input_enable,
	input wire logic [15:0] port_latch,
	input wire logic [15:0] pad_in,
	output logic [15:0] pad_out,
	output logic [15:0] pad_oe,
	input wire logic [25:0] fn_out,
	input wire logic [25:0] fn_drive,
	output logic [25:0] fn_in,
	input wire logic [7:0] ext_int_pin_config,
	input wire logic [7:0] port_a_match_mask,
	input wire logic [7:0] port_a_match_value,
	input wire logic [7:0] port_b_match_mask,
	input wire logic [7:0] port_b_match_value,
	output logic int0_level,
	output logic int1_level,
	output logic int0_edge,
	output logic int1_edge,
	output logic port_match,
	output logic [4:0] fixed_analog_connect
);
	localparam int NP = pcpa_pkg::NPIN;
	localparam int NF = pcpa_pkg::NFUNC;

	// ----------------------------------------
	// Requests
	// ----------------------------------------
	wire [7:0] ra;
	wire [7:0] rb;
	wire [NF-1:0] req;
	wire [2:0] cex_cnt;

	assign ra = crossbar_enable_reg_a;
	assign rb = crossbar_enable_reg_b;
	assign cex_cnt = rb[pcpa_pkg::RB_CEX_HI:pcpa_pkg::RB_CEX_LO];

	assign req[pcpa_pkg::F_TX] = ra[pcpa_pkg::RA_URT];
	assign req[pcpa_pkg::F_RX] = ra[pcpa_pkg::RA_URT];
	assign req[pcpa_pkg::F_SPIB+3:pcpa_pkg::F_SPIB] =
		{4{crossbar_enable_reg_c[pcpa_pkg::RC_SPIB]}};
	assign req[pcpa_pkg::F_SCKA] = ra[pcpa_pkg::RA_SPIA];
	assign req[pcpa_pkg::F_MISOA] = ra[pcpa_pkg::RA_SPIA];
	assign req[pcpa_pkg::F_MOSIA] = ra[pcpa_pkg::RA_SPIA];
	assign req[pcpa_pkg::F_NSSA] = ra[pcpa_pkg::RA_SPIA] &
		slave_select_mode_field[pcpa_pkg::SSM_4WIRE];
	assign req[pcpa_pkg::F_SDA] = ra[pcpa_pkg::RA_SMB];
	assign req[pcpa_pkg::F_SCL] = ra[pcpa_pkg::RA_SMB];
	assign req[pcpa_pkg::F_CMPA] = ra[pcpa_pkg::RA_CMPA];
	assign req[pcpa_pkg::F_CMPAA] = ra[pcpa_pkg::RA_CMPAA];
	assign req[pcpa_pkg::F_CMPB] = ra[pcpa_pkg::RA_CMPB];
	assign req[pcpa_pkg::F_CMPBA] = ra[pcpa_pkg::RA_CMPBA];
	assign req[pcpa_pkg::F_SYSCK] = ra[pcpa_pkg::RA_SYSCK];
	assign req[pcpa_pkg::F_ECI] = rb[pcpa_pkg::RB_ECI];
	assign req[pcpa_pkg::F_T0] = rb[pcpa_pkg::RB_T0];
	assign req[pcpa_pkg::F_T1] = rb[pcpa_pkg::RB_T1];

	genvar gi;
	generate
		for (gi = 0; gi < pcpa_pkg::NCEX; gi++) begin : g_cex
			// Channel count field enables the first N channels
			assign req[pcpa_pkg::F_CEX+gi] = (cex_cnt > 3'(gi));
		end
	endgenerate

	// ----------------------------------------
	// Pin search
	// ----------------------------------------
	wire [NP-1:0] grant [NF];
	wire [NP-1:0] free_c [NF+1];
	wire [NP-1:0] skip;
	wire [NP-1:0] fixed_taken;
	wire [NP-1:0] one;

	assign one = {{(NP-1){1'b0}}, 1'b1};
	// A set skip bit, e.g. mask 0C on port A, keeps the pin out
	assign skip = {port_b_skip_mask[6:0], port_a_skip_mask};

	// Fixed placements ignore the skip mask
	assign grant[pcpa_pkg::F_TX] = req[pcpa_pkg::F_TX] ?
		(one << pcpa_pkg::PIN_TX) : '0;
	assign grant[pcpa_pkg::F_RX] = req[pcpa_pkg::F_RX] ?
		(one << pcpa_pkg::PIN_RX) : '0;
	generate
		for (gi = 0; gi < 4; gi++) begin : g_spib
			assign grant[pcpa_pkg::F_SPIB+gi] =
				req[pcpa_pkg::F_SPIB+gi] ?
				(one << (pcpa_pkg::PIN_SPIB + gi)) : '0;
		end
	endgenerate

	assign fixed_taken = grant[0] | grant[1] | grant[2] |
		grant[3] | grant[4] | grant[5];
	assign free_c[pcpa_pkg::NFIX] = ~skip & ~fixed_taken;

	generate
		for (gi = 0; gi < pcpa_pkg::NFIX; gi++) begin : g_nofree
			assign free_c[gi] = '0;
		end
		for (gi = pcpa_pkg::NFIX; gi < NF; gi++) begin : g_slot
			pcpa_slot #(
				.W(NP)
			) u_slot (
				.req(req[gi]),
				.free_in(free_c[gi]),
				.grant(grant[gi]),
				.free_out(free_c[gi+1])
			);
		end
	endgenerate

	// ----------------------------------------
	// Pad drive and input return
	// ----------------------------------------
	logic [NP-1:0] owned;
	logic [NP-1:0] own_out;
	logic [NP-1:0] own_drv;
	logic [NF-1:0] fn_in_nxt;
	logic [NP-1:0] dup;
	localparam int NPAD_W = pcpa_pkg::NPAD;
	wire [NP-1:0] dig_in;
	wire [NP-1:0] smb_pin;
	wire [NP-1:0] val;
	wire [NP-1:0] drv;
	wire [NP-1:0] pp;
	wire [NPAD_W-1:0] oe_nxt;
	wire [NPAD_W-1:0] out_nxt;
	wire [4:0] analog_nxt;

	// Analog pins read as zero to every digital consumer
	assign dig_in = pad_in[NP-1:0] & digital_input_enable[NP-1:0];

	always_comb begin
		owned = '0;
		own_out = '0;
		own_drv = '0;
		fn_in_nxt = '0;
		dup = '0;
		for (int f = 0; f < NF; f++) begin
			// Any pin granted to a second function
			dup = dup | (owned & grant[f]);
			owned = owned | grant[f];
			own_out = own_out | (grant[f] & {NP{fn_out[f]}});
			own_drv = own_drv | (grant[f] & {NP{fn_drive[f]}});
			// Unplaced inputs idle high
			fn_in_nxt[f] = (grant[f] == '0) |
				(|(grant[f] & dig_in));
		end
	end

	assign smb_pin = grant[pcpa_pkg::F_SDA] | grant[pcpa_pkg::F_SCL];
	assign val = (owned & own_out) | (~owned & port_latch[NP-1:0]);
	assign drv = (owned & own_drv) | ~owned;
	assign pp = output_mode_select[NP-1:0] & ~smb_pin;

	// Open-drain only pulls low; push-pull drives both rails
	assign oe_nxt[NP-1:0] = {NP{crossbar_global_enable}} &
		drv & (pp | ~val);
	assign oe_nxt[pcpa_pkg::PAD_GPIO2] = crossbar_global_enable &
		(output_mode_select[pcpa_pkg::PAD_GPIO2] |
		~port_latch[pcpa_pkg::PAD_GPIO2]);
	assign out_nxt = {port_latch[pcpa_pkg::PAD_GPIO2], val};

	// Analog paths connect when their fixed pin is not digital
	assign analog_nxt = ~{digital_input_enable[pcpa_pkg::PIN_IREF],
		digital_input_enable[pcpa_pkg::PIN_XOUT],
		digital_input_enable[pcpa_pkg::PIN_XIN],
		digital_input_enable[pcpa_pkg::PIN_ANALOG_GROUND_PIN],
		digital_input_enable[pcpa_pkg::PIN_VREF]};

	// ----------------------------------------
	// Output registers
	// ----------------------------------------
	always_ff @(posedge core_clk) begin
		if (rst) begin
			pad_out <= '0;
			pad_oe <= '0;
			fn_in <= '1;
			fixed_analog_connect <= '0;
		end else begin
			pad_out <= out_nxt;
			pad_oe <= oe_nxt;
			fn_in <= fn_in_nxt;
			fixed_analog_connect <= analog_nxt;
		end
	end

	// ----------------------------------------
	// Event capture
	// ----------------------------------------
	pcpa_evt #(
		.W(NP)
	) u_evt (
		.core_clk(core_clk),
		.rst(rst),
		.pin_in(dig_in),
		.ext_int_pin_config(ext_int_pin_config),
		.match_mask({port_b_match_mask[6:0], port_a_match_mask}),
		.match_value({port_b_match_value[6:0], port_a_match_value}),
		.int0_level(int0_level),
		.int1_level(int1_level),
		.int0_edge(int0_edge),
		.int1_edge(int1_edge),
		.port_match(port_match)
	);

	// ----------------------------------------
	// Assertions
	// ----------------------------------------
	property p_drv_off;
		@(posedge core_clk) disable iff (rst)
		!crossbar_global_enable |=> pad_oe == '0;
	endproperty
	a_drv_off: assert property (p_drv_off)
		else $error("pad driven with crossbar disabled");

	property p_tx_fixed;
		@(posedge core_clk) disable iff (rst)
		ra[pcpa_pkg::RA_URT] |=>
		pad_out[pcpa_pkg::PIN_TX] == $past(fn_out[pcpa_pkg::F_TX]);
	endproperty
	a_tx_fixed: assert property (p_tx_fixed)
		else $error("serial transmit not on its fixed pin");

	property p_spib_fixed;
		@(posedge core_clk) disable iff (rst)
		crossbar_enable_reg_c[pcpa_pkg::RC_SPIB] |=>
		pad_out[pcpa_pkg::PIN_SPIB+3] ==
		$past(fn_out[pcpa_pkg::F_SPIB+3]);
	endproperty
	a_spib_fixed: assert property (p_spib_fixed)
		else $error("spi port b line not on its fixed pin");

	property p_skip_kept;
		@(posedge core_clk) disable iff (rst)
		(owned & ~fixed_taken & skip) == '0;
	endproperty
	a_skip_kept: assert property (p_skip_kept)
		else $error("skipped pin claimed by crossbar");

	property p_no_overlap;
		@(posedge core_clk) disable iff (rst)
		dup == '0;
	endproperty
	a_no_overlap: assert property (p_no_overlap)
		else $error("pin assigned twice");

	property p_lowest;
		@(posedge core_clk) disable iff (rst)
		req[pcpa_pkg::F_SCKA] && free_c[pcpa_pkg::NFIX] != '0 |->
		$onehot(grant[pcpa_pkg::F_SCKA]) &&
		(grant[pcpa_pkg::F_SCKA] & free_c[pcpa_pkg::NFIX]) != '0 &&
		((grant[pcpa_pkg::F_SCKA] - one) &
		free_c[pcpa_pkg::NFIX]) == '0;
	endproperty
	a_lowest: assert property (p_lowest)
		else $error("first floating function missed lowest pin");

	property p_nss_3wire;
		@(posedge core_clk) disable iff (rst)
		!slave_select_mode_field[pcpa_pkg::SSM_4WIRE] |->
		grant[pcpa_pkg::F_NSSA] == '0;
	endproperty
	a_nss_3wire: assert property (p_nss_3wire)
		else $error("slave select placed in 3-wire mode");

	property p_smb_od;
		@(posedge core_clk) disable iff (rst)
		(smb_pin & own_out) != '0 |=>
		(pad_oe[NP-1:0] & $past(smb_pin & own_out)) == '0;
	endproperty
	a_smb_od: assert property (p_smb_od)
		else $error("smbus pin driven high");

	property p_gpio2;
		@(posedge core_clk) disable iff (rst)
		crossbar_global_enable &&
		output_mode_select[pcpa_pkg::PAD_GPIO2] |=>
		pad_oe[pcpa_pkg::PAD_GPIO2] && pad_out[pcpa_pkg::PAD_GPIO2] ==
		$past(port_latch[pcpa_pkg::PAD_GPIO2]);
	endproperty
	a_gpio2: assert property (p_gpio2)
		else $error("P2.7 push-pull gpio not driven");

	property p_analog_quiet;
		@(posedge core_clk) disable iff (rst)
		ext_int_pin_config[3] &&
		!digital_input_enable[ext_int_pin_config[2:0]] |=> !int0_edge;
	endproperty
	a_analog_quiet: assert property (p_analog_quiet)
		else $error("edge captured on analog pin");
endmodule

// File: verilog/pcpa_xbar_fix_note.sv
// Unused.
